//--- hdl/cmpe_top.sv
// cmpe_top: control, status and event logic around an on-chip comparator
// assumes: analog result and pin-sharing inputs asynchronous, register port on ref_clk
`timescale 1ns/1ps

// What this block does
// - live synchronised comparator result readable as read-only status bit
// - power-off control bit switches comparator power off, writable anytime
// - bandgap select bit routes fixed reference to positive input instead of pin
// - event flag sets when output change matches selected event mode
// - comparator interrupt request only while flag, irq enable and global enable are set
// - flag clears when processor acknowledges the comparator vector
// - writing one to flag position clears it, zero leaves it
// - capture route bit feeds comparator output to timer capture front-end
// - mode 00 toggle, 01 reserved, 10 falling, 11 rising edge
// - second uart enable overrides shared comparator pin direction
// - fields: off 7, bandgap 6, result 5, flag 4, enable 3, capture 2, mode 1:0
module cmpe_top (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // processor side
  input  wire logic       global_irq_enable,
  input  wire logic       vector_ack,
  output logic            comparator_irq,
  output logic            block_irq,
  // analog front end
  input  wire logic       comparator_raw,
  output logic            comparator_power_off,
  output logic            bandgap_input_select,
  // timer capture front-end
  output logic            capture_input,
  output logic            capture_input_valid,
  // shared pins
  input  wire logic       uart_tx_enable,
  input  wire logic       uart_rx_enable,
  input  wire logic [1:0] port_b_direction,
  output logic      [1:0] pin_direction
);

  // ==========================================================================
  // synchronised inputs
  logic [2:0] sync_level;
  logic       result_now;
  logic       result_prev;
  logic       uart_tx_on;
  logic       uart_rx_on;

  cmpe_sync #(
    .WIDTH(3)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({uart_rx_enable, uart_tx_enable, comparator_raw}),
    .sync_out (sync_level)
  );

  assign result_now = sync_level[0];
  assign uart_tx_on = sync_level[1];
  assign uart_rx_on = sync_level[2];

  // ==========================================================================
  // state
  cmpe_pkg::cmpe_ctrl_type          ctrl;
  logic                             event_flag;
  logic [cmpe_pkg::STATUS_WIDTH-1:0] irq_status;
  logic [cmpe_pkg::STATUS_WIDTH-1:0] irq_mask;

  // ==========================================================================
  // decode
  function automatic logic hit(input logic [1:0] a, input logic [1:0] target);
    hit = (a == target);
  endfunction : hit

  wire        wr_ctrl   = reg_wr && hit(reg_addr, cmpe_pkg::ADDR_CTRL_STATUS);
  wire        wr_status = reg_wr && hit(reg_addr, cmpe_pkg::ADDR_IRQ_STATUS);
  wire        wr_mask   = reg_wr && hit(reg_addr, cmpe_pkg::ADDR_IRQ_MASK);

  wire        rise_seen = result_now && !result_prev;
  wire        fall_seen = !result_now && result_prev;
  logic       event_hit;

  always_comb begin
    case (ctrl.mode)
      cmpe_pkg::MODE_TOGGLE:   event_hit = rise_seen || fall_seen;
      cmpe_pkg::MODE_FALL:     event_hit = fall_seen;
      cmpe_pkg::MODE_RISE:     event_hit = rise_seen;
      cmpe_pkg::MODE_RESERVED: event_hit = 1'b0;
      default:                 event_hit = 1'b0;
    endcase
  end

  // set wins over both clear sources
  wire flag_clear = (wr_ctrl && reg_wdata[cmpe_pkg::BIT_EVENT_FLAG])
                    || vector_ack;
  wire next_event_flag = event_hit || (event_flag && !flag_clear);

  wire [cmpe_pkg::STATUS_WIDTH-1:0] status_set = {vector_ack, event_hit};
  wire [cmpe_pkg::STATUS_WIDTH-1:0] status_clr = wr_status ?
      reg_wdata[cmpe_pkg::STATUS_WIDTH-1:0] : {cmpe_pkg::STATUS_WIDTH{1'b0}};
  wire [cmpe_pkg::STATUS_WIDTH-1:0] next_irq_status =
      status_set | (irq_status & ~status_clr);

  wire [7:0] ctrl_view = {ctrl.power_off, ctrl.bandgap_sel, result_now, event_flag,
                          ctrl.irq_enable, ctrl.capture_route, ctrl.mode};

  logic [7:0] next_rdata;
  always_comb begin
    case (reg_addr)
      cmpe_pkg::ADDR_CTRL_STATUS: next_rdata = ctrl_view;
      cmpe_pkg::ADDR_IRQ_STATUS:  next_rdata = {6'h00, irq_status};
      cmpe_pkg::ADDR_IRQ_MASK:    next_rdata = {6'h00, irq_mask};
      cmpe_pkg::ADDR_PIN_STATUS:  next_rdata = {5'h00, uart_rx_on, uart_tx_on, result_now};
      default:                    next_rdata = 8'h00;
    endcase
  end

  wire       uart_owns  = uart_tx_on || uart_rx_on;
  wire [1:0] next_dir   = uart_owns ? {1'b0, uart_tx_on} : port_b_direction;
  wire       next_irq_enable = wr_ctrl ? reg_wdata[cmpe_pkg::BIT_IRQ_ENABLE] : ctrl.irq_enable;
  wire       next_irq   = next_event_flag && next_irq_enable && global_irq_enable;

  // ==========================================================================
  // control register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl.power_off     <= cmpe_pkg::RESET_CTRL[cmpe_pkg::BIT_POWER_OFF];
      ctrl.bandgap_sel   <= cmpe_pkg::RESET_CTRL[cmpe_pkg::BIT_BANDGAP_SEL];
      ctrl.irq_enable    <= cmpe_pkg::RESET_CTRL[cmpe_pkg::BIT_IRQ_ENABLE];
      ctrl.capture_route <= cmpe_pkg::RESET_CTRL[cmpe_pkg::BIT_CAPTURE];
      ctrl.mode          <= cmpe_pkg::cmpe_mode_type'(
                            cmpe_pkg::RESET_CTRL[cmpe_pkg::BIT_MODE_HIGH:cmpe_pkg::BIT_MODE_LOW]);
    end else if (wr_ctrl) begin
      ctrl.power_off     <= reg_wdata[cmpe_pkg::BIT_POWER_OFF];
      ctrl.bandgap_sel   <= reg_wdata[cmpe_pkg::BIT_BANDGAP_SEL];
      ctrl.irq_enable    <= reg_wdata[cmpe_pkg::BIT_IRQ_ENABLE];
      ctrl.capture_route <= reg_wdata[cmpe_pkg::BIT_CAPTURE];
      ctrl.mode          <= cmpe_pkg::cmpe_mode_type'(
                            reg_wdata[cmpe_pkg::BIT_MODE_HIGH:cmpe_pkg::BIT_MODE_LOW]);
    end
  end

  // ==========================================================================
  // flags and interrupt status
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_flag  <= 1'b0;
      result_prev <= 1'b0;
      irq_status  <= '0;
      irq_mask    <= cmpe_pkg::RESET_MASK;
    end else begin
      event_flag  <= next_event_flag;
      result_prev <= result_now;
      irq_status  <= next_irq_status;
      if (wr_mask) begin
        irq_mask <= reg_wdata[cmpe_pkg::STATUS_WIDTH-1:0];
      end
    end
  end

  // ==========================================================================
  // registered outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata            <= 8'h00;
      comparator_irq       <= 1'b0;
      block_irq            <= 1'b0;
      comparator_power_off <= 1'b0;
      bandgap_input_select <= 1'b0;
      capture_input        <= 1'b0;
      capture_input_valid  <= 1'b0;
      pin_direction        <= 2'h0;
    end else begin
      reg_rdata            <= reg_rd ? next_rdata : 8'h00;
      comparator_irq       <= next_irq;
      block_irq            <= |(next_irq_status & irq_mask);
      comparator_power_off <= wr_ctrl ? reg_wdata[cmpe_pkg::BIT_POWER_OFF]
                                      : ctrl.power_off;
      bandgap_input_select <= wr_ctrl ? reg_wdata[cmpe_pkg::BIT_BANDGAP_SEL]
                                      : ctrl.bandgap_sel;
      capture_input        <= ctrl.capture_route && result_now;
      capture_input_valid  <= ctrl.capture_route;
      pin_direction        <= next_dir;
    end
  end

endmodule : cmpe_top

//--- common/cmpe_pkg.sv
// cmpe_pkg: constants and carrier types for the comparator event control block
// assumes: nothing beyond a SystemVerilog compiler
package cmpe_pkg;

  // ==========================================================================
  // register map
  localparam logic [1:0] ADDR_CTRL_STATUS = 2'h0;
  localparam logic [1:0] ADDR_IRQ_STATUS  = 2'h1;
  localparam logic [1:0] ADDR_IRQ_MASK    = 2'h2;
  localparam logic [1:0] ADDR_PIN_STATUS  = 2'h3;

  // ==========================================================================
  // control and status field positions
  localparam int BIT_POWER_OFF   = 7;
  localparam int BIT_BANDGAP_SEL = 6;
  localparam int BIT_RESULT      = 5;
  localparam int BIT_EVENT_FLAG  = 4;
  localparam int BIT_IRQ_ENABLE  = 3;
  localparam int BIT_CAPTURE     = 2;
  localparam int BIT_MODE_HIGH   = 1;
  localparam int BIT_MODE_LOW    = 0;

  // ==========================================================================
  // status register bits (sticky, write one to clear)
  localparam int SBIT_CMP_EVENT  = 0;
  localparam int SBIT_VECTOR     = 1;
  localparam int STATUS_WIDTH    = 2;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RESET_CTRL = 8'h00;
  localparam logic [1:0] RESET_MASK = 2'h0;

  // ==========================================================================
  // event modes
  typedef enum logic [1:0] {
    MODE_TOGGLE   = 2'h0,
    MODE_RESERVED = 2'h1,
    MODE_FALL     = 2'h2,
    MODE_RISE     = 2'h3
  } cmpe_mode_type;

  // ==========================================================================
  // control fields carried together
  typedef struct packed {
    logic          power_off;
    logic          bandgap_sel;
    logic          irq_enable;
    logic          capture_route;
    cmpe_mode_type mode;
  } cmpe_ctrl_type;

  // register port request
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cmpe_req_type;

endpackage : cmpe_pkg

//--- hdl/cmpe_sync.sv
// cmpe_sync: two flip-flop synchroniser for a vector of pin levels
// assumes: inputs asynchronous to ref_clk, reset asynchronous active low
`timescale 1ns/1ps
module cmpe_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // ==========================================================================
  // per-bit chains
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          stage_one[gi] <= 1'b0;
          sync_out[gi]  <= 1'b0;
        end else begin
          stage_one[gi] <= async_in[gi];
          sync_out[gi]  <= stage_one[gi];
        end
      end
    end
  endgenerate

endmodule : cmpe_sync

//--- bench/cmpe_analog_model.sv
// cmpe_analog_model: behavioural comparator in front of the block
// assumes: outcomes of both compares given as levels by the bench
`timescale 1ns/1ps
module cmpe_analog_model (
  // compare outcomes against the negative input
  input  wire logic pin_above,
  input  wire logic ref_above,
  // controls from the block
  input  wire logic power_off,
  input  wire logic bandgap_sel,
  // timer capture side
  input  wire logic capture_in,
  input  wire logic capture_valid,
  input  wire logic capture_irq_mask,
  // results
  output logic      comparator_raw,
  output logic      capture_irq
);
  // unpowered comparator rests low
  assign comparator_raw = power_off ? 1'b0
                                    : (bandgap_sel ? ref_above : pin_above);
  // timer capture interrupt only with its own mask set
  assign capture_irq = capture_valid && capture_in && capture_irq_mask;
endmodule : cmpe_analog_model

//--- bench/cmpe_properties.sv
// cmpe_properties: port-level checks of the comparator event block
// assumes: bound to cmpe_top, one clock, rst_n active low
`timescale 1ns/1ps
module cmpe_properties (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // outputs and pin-sharing inputs
  input wire logic       global_irq_enable,
  input wire logic       comparator_irq,
  input wire logic       comparator_power_off,
  input wire logic       bandgap_input_select,
  input wire logic       capture_input,
  input wire logic       capture_input_valid,
  input wire logic       uart_tx_enable,
  input wire logic       uart_rx_enable,
  input wire logic [1:0] port_b_direction,
  input wire logic [1:0] pin_direction
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire cw      = reg_wr && (reg_addr == 2'h0);
  wire no_uart = !uart_tx_enable && !uart_rx_enable;
  // ==========================================================================
  // properties
  property p_gie; comparator_irq |-> $past(global_irq_enable); endproperty
  a_gie: assert property (p_gie) else $error("irq without global enable");
  property p_off; cw |=> comparator_power_off == $past(reg_wdata[7]); endproperty
  a_off: assert property (p_off) else $error("power off bit wrong");
  property p_bg; cw |=> bandgap_input_select == $past(reg_wdata[6]); endproperty
  a_bg: assert property (p_bg) else $error("bandgap select wrong");
  property p_capv; cw |-> ##2 capture_input_valid == $past(reg_wdata[2], 2); endproperty
  a_capv: assert property (p_capv) else $error("capture route wrong");
  property p_cap; !capture_input_valid |-> !capture_input; endproperty
  a_cap: assert property (p_cap) else $error("capture driven unrouted");
  property p_rd; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
  property p_tx; uart_tx_enable [*5] |-> pin_direction == 2'h1; endproperty
  a_tx: assert property (p_tx) else $error("uart override missing");
  property p_sw; no_uart [*5] |-> pin_direction == $past(port_b_direction); endproperty
  a_sw: assert property (p_sw) else $error("software direction lost");
endmodule : cmpe_properties
bind cmpe_top cmpe_properties cmpe_properties_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .global_irq_enable(global_irq_enable), .comparator_irq(comparator_irq),
  .comparator_power_off(comparator_power_off), .bandgap_input_select(bandgap_input_select),
  .capture_input(capture_input), .capture_input_valid(capture_input_valid),
  .uart_tx_enable(uart_tx_enable), .uart_rx_enable(uart_rx_enable),
  .port_b_direction(port_b_direction), .pin_direction(pin_direction));

//--- bench/testbench.sv
// testbench: register-level tests of the comparator event block
// assumes: cmpe_top, cmpe_analog_model and the bound checker
`timescale 1ns/1ps
module testbench;
  logic       ref_clk, rst_n, reg_wr, reg_rd, global_irq_enable, vector_ack;
  logic       comparator_irq, block_irq, comparator_raw, comparator_power_off;
  logic       bandgap_input_select, capture_input, capture_input_valid;
  logic       uart_tx_enable, uart_rx_enable, pin_above, ref_above, fr, ff;
  logic       timer_capture_irq_mask, capture_irq;
  logic [1:0] reg_addr, port_b_direction, pin_direction, md;
  logic [7:0] reg_wdata, reg_rdata;
  int         error_cnt, cmp_count;
  cmpe_top cmpe_top_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
    .comparator_irq(comparator_irq), .block_irq(block_irq), .comparator_raw(comparator_raw),
    .comparator_power_off(comparator_power_off), .bandgap_input_select(bandgap_input_select),
    .capture_input(capture_input), .capture_input_valid(capture_input_valid),
    .uart_tx_enable(uart_tx_enable), .uart_rx_enable(uart_rx_enable),
    .port_b_direction(port_b_direction), .pin_direction(pin_direction));
  cmpe_analog_model cmpe_analog_model_inst (.pin_above(pin_above), .ref_above(ref_above),
    .power_off(comparator_power_off), .bandgap_sel(bandgap_input_select),
    .capture_in(capture_input), .capture_valid(capture_input_valid),
    .capture_irq_mask(timer_capture_irq_mask),
    .comparator_raw(comparator_raw), .capture_irq(capture_irq));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ==========================================================================
  // tasks
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle
  task automatic stop_test;
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  initial begin
    #2000000;
    error_cnt++;
    stop_test();
  end
  // ==========================================================================
  // main sequence
  initial begin
    {reg_wr, reg_rd, global_irq_enable, vector_ack, uart_tx_enable, uart_rx_enable} = '0;
    {pin_above, ref_above, rst_n} = '0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    port_b_direction = 2'h2;
    timer_capture_irq_mask = 1'b1;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(2'h0, 8'h00);
    rd(2'h2, 8'h00);
    pin_above <= 1'b1;
    idle(5);
    rd(2'h0, 8'h30);
    rd(2'h3, 8'h01);
    wr(2'h0, 8'h50);
    idle(5);
    rd(2'h0, 8'h50);
    wr(2'h0, 8'h90);
    rd(2'h0, 8'h80);
    wr(2'h0, 8'h04);
    idle(5);
    chk("capture_input", 8'h03, {6'h00, capture_input_valid, capture_input});
    chk("capture_irq", 8'h01, 8'(capture_irq));
    pin_above <= 1'b0;
    wr(2'h0, 8'h10);
    idle(5);
    chk("capture_input", 8'h00, {6'h00, capture_input_valid, capture_input});
    chk("capture_irq", 8'h00, 8'(capture_irq));
    chk("block_irq", 8'h00, 8'(block_irq));
    wr(2'h2, 8'h01);
    idle(2);
    chk("block_irq", 8'h01, 8'(block_irq));
    rd(2'h2, 8'h01);
    global_irq_enable <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      md = 2'(i);
      fr = (md == 2'h0) || (md == 2'h3);
      ff = (md == 2'h0) || (md == 2'h2);
      wr(2'h0, {4'h1, 2'h0, md});
      wr(2'h0, {4'h0, 2'h2, md});
      pin_above <= 1'b1;
      idle(5);
      rd(2'h0, {2'h0, 1'b1, fr, 2'h2, md});
      chk("comparator_irq", 8'(fr), 8'(comparator_irq));
      @(posedge ref_clk);
      vector_ack <= 1'b1;
      @(posedge ref_clk);
      vector_ack <= 1'b0;
      rd(2'h0, {4'h2, 2'h2, md});
      pin_above <= 1'b0;
      idle(5);
      rd(2'h0, {2'h0, 1'b0, ff, 2'h2, md});
      wr(2'h0, {4'h0, 2'h2, md});
      rd(2'h0, {2'h0, 1'b0, ff, 2'h2, md});
      wr(2'h0, {4'h1, 2'h2, md});
      rd(2'h0, {4'h0, 2'h2, md});
    end
    rd(2'h1, 8'h03);
    wr(2'h1, 8'h03);
    rd(2'h1, 8'h00);
    chk("block_irq", 8'h00, 8'(block_irq));
    uart_tx_enable <= 1'b1;
    idle(5);
    chk("pin_direction", 8'h01, 8'(pin_direction));
    rd(2'h3, 8'h02);
    uart_tx_enable <= 1'b0;
    uart_rx_enable <= 1'b1;
    idle(5);
    chk("pin_direction", 8'h00, 8'(pin_direction));
    uart_rx_enable <= 1'b0;
    idle(5);
    chk("pin_direction", 8'h02, 8'(pin_direction));
    stop_test();
  end
endmodule : testbench
